//--- dv/tdm_port_reset_cond_regs_bench.sv
// self-checking bench of the register bank
`timescale 1ns/1ps

module tdm_port_reset_cond_regs_bench;
  import tpcr_pkg::*;
  logic clk, srst, cpu_wr_en, cpu_rd_en, cpu_rvalid;  // clock, strobes
  logic [7:0] cpu_addr;                                // byte address
  logic [31:0] cpu_wdata, cpu_rdata;                   // bus data
  logic [7:0] port_two_clock, port_tx_in_rise;         // port edges
  logic [7:0] port_tx_out_fall, port_rx_in_rise;       // port edges
  tpcr_framing_t port_framing [8];                     // framing
  tpcr_line_t port_line [8];                           // line type
  logic tx_rst_req, tx_rst_open, tx_rst_ack;           // tx reset
  logic rx_rst_req, rx_rst_ack;                        // rx reset
  logic [3:0] tx_rst_port;                             // tx port
  logic [5:0] tx_rst_bundle, rx_rst_bundle;            // bundles
  logic jb_underrun, tdm_fill_valid;                   // tdm fill
  logic net_no_data, net_fill_allowed, net_fill_valid; // net fill
  logic [1:0] tdm_fill_index, net_fill_select;         // octet picks
  logic [7:0] tdm_fill_byte, net_fill_byte;            // fill octets
  logic [31:0] local_ip_first, local_ip_second;        // addresses
  logic [47:0] local_station_first;                    // station
  int miscompares = 0;                                 // mismatches
  int checks = 0;                                      // comparisons

  tpcr_regs #(.NUM_PORTS(8)) DUT (.clk, .srst, .cpu_addr, .cpu_wr_en,
    .cpu_rd_en, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .port_two_clock,
    .port_tx_in_rise, .port_tx_out_fall, .port_rx_in_rise, .port_framing,
    .port_line, .tx_rst_req, .tx_rst_port, .tx_rst_bundle, .tx_rst_open,
    .tx_rst_ack, .rx_rst_req, .rx_rst_bundle, .rx_rst_ack, .jb_underrun,
    .tdm_fill_index, .tdm_fill_byte, .tdm_fill_valid, .net_no_data,
    .net_fill_allowed, .net_fill_select, .net_fill_byte, .net_fill_valid,
    .local_ip_first, .local_ip_second, .local_station_first);

  // free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare one value, four-state exact
  task automatic chk(input string n, input logic [47:0] e,
                     input logic [47:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one-cycle write strobe, driven off the sampling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    cpu_wr_en = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_wr_en = 1'b0;
    @(negedge clk);
  endtask : wr

  // read strobe; answer lands one edge later
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    cpu_rd_en = 1'b1;
    cpu_addr = a;
    @(negedge clk);
    cpu_rd_en = 1'b0;
    chk("rvalid", 48'h1, {47'h0, cpu_rvalid});
    chk("rdata", {16'h0, e}, {16'h0, cpu_rdata});
  endtask : rd

  // reset values and an unmapped read
  task automatic t_reset();
    for (int i = 0; i < 8; i++)
      rd(8'(8 + 4 * i), 32'h51);
    for (int a = 8'h2C; a <= 8'h44; a += 4)
      rd(8'(a), 32'h0);
    rd(8'hFC, 32'h0);
    chk("two_clock", 48'hFF, {40'h0, port_two_clock});
    chk("line", 48'h1, {46'h0, port_line[0]});
    $display("reset test done");
  endtask : t_reset

  // framing codes, edge fields, line types incl. refused code
  task automatic t_port();
    for (int f = 0; f < 4; f++)
    begin
      wr(8'h08, 32'h11 | 32'(f << 2));
      chk("framing", 48'(f), {46'h0, port_framing[0]});
    end
    // a system reset brings the port word back to its reset value
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    rd(8'h08, 32'h51);
    wr(8'h08, 32'h23);
    rd(8'h08, 32'h21);
    chk("tx_edges", 48'h3, {46'h0, port_tx_in_rise[0],
        port_tx_out_fall[0]});
    chk("rx_one_clk", 48'h1, {47'h0, port_rx_in_rise[0]});
    chk("two_clock", 48'h0, {47'h0, port_two_clock[0]});
    wr(8'h08, 32'h12);
    chk("rx_two_clk", 48'h0, {47'h0, port_rx_in_rise[0]});
    chk("line_t1", 48'h2, {46'h0, port_line[0]});
    wr(8'h08, 32'h52);
    chk("rx_edge", 48'h1, {47'h0, port_rx_in_rise[0]});
    chk("tx_rise", 48'h0, {46'h0, port_tx_in_rise[0],
        port_tx_out_fall[0]});
    wr(8'h08, 32'h10);
    chk("line_ser", 48'h0, {46'h0, port_line[0]});
    wr(8'h24, 32'hFFFF_FF7E);
    rd(8'h24, 32'h7E);
    $display("port test done");
  endtask : t_port

  // transmit and receive reset requests with acknowledge
  task automatic t_reset_req();
    wr(8'h2C, 32'h07FF_007F);
    rd(8'h2C, 32'h07FF_007F);
    chk("tx_fields", 48'h3FF, {37'h0, tx_rst_port, tx_rst_bundle,
        tx_rst_open});
    @(negedge clk);
    tx_rst_ack = 1'b1;
    @(negedge clk);
    tx_rst_ack = 1'b0;
    rd(8'h2C, 32'h07FE_007F);
    @(negedge clk);
    rx_rst_ack = 1'b1;
    @(negedge clk);
    rx_rst_ack = 1'b0;
    rd(8'h2C, 32'h07FE_007E);
    wr(8'h2C, 32'h0001_000B);
    wr(8'h2C, 32'h0000_0004);
    chk("tx_cleared", 48'h0, {47'h0, tx_rst_req});
    chk("rx_sticky", 48'h1, {47'h0, rx_rst_req});
    chk("rx_bundle", 48'h2, {42'h0, rx_rst_bundle});
    @(negedge clk);
    rx_rst_ack = 1'b1;
    @(negedge clk);
    rx_rst_ack = 1'b0;
    chk("rx_acked", 48'h0, {47'h0, rx_rst_req});
    $display("reset request test done");
  endtask : t_reset_req

  // conditioning octets in both directions
  task automatic t_fill();
    wr(8'h30, 32'h1122_3344);
    wr(8'h34, 32'hA1B2_C3D4);
    jb_underrun = 1'b1;
    net_no_data = 1'b1;
    net_fill_allowed = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      tdm_fill_index = 2'(i);
      net_fill_select = 2'(i);
      @(negedge clk);
      chk("tdm_fill",
          48'h1_00 | 48'((32'h1122_3344 >> (24 - 8 * i)) & 8'hFF),
          {39'h0, tdm_fill_valid, tdm_fill_byte});
      chk("net_fill",
          48'h1_00 | 48'((32'hA1B2_C3D4 >> (8 * i)) & 8'hFF),
          {39'h0, net_fill_valid, net_fill_byte});
    end
    jb_underrun = 1'b0;
    net_fill_allowed = 1'b0;
    @(negedge clk);
    chk("fill_off", 48'h0, {46'h0, tdm_fill_valid, net_fill_valid});
    net_fill_allowed = 1'b1;
    net_no_data = 1'b0;
    @(negedge clk);
    chk("net_data", 48'h0, {47'h0, net_fill_valid});
    wr(8'h30, 32'h7E7E_7E7E);
    rd(8'h30, 32'h7E7E_7E7E);
    $display("fill test done");
  endtask : t_fill

  // classifier addresses and station address halves
  task automatic t_addr();
    wr(8'h38, 32'h0A00_0001);
    wr(8'h3C, 32'hC0A8_0001);
    wr(8'h40, 32'h89AB_CDEF);
    wr(8'h44, 32'hFFFF_0123);
    rd(8'h44, 32'h0000_0123);
    rd(8'h40, 32'h89AB_CDEF);
    chk("ip_first", 48'h0A00_0001, {16'h0, local_ip_first});
    chk("ip_second", 48'hC0A8_0001, {16'h0, local_ip_second});
    chk("station", 48'h0123_89AB_CDEF, local_station_first);
    $display("address test done");
  endtask : t_addr

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // watchdog sized well past the expected run
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end

  // main sequence
  initial
  begin
    {srst, cpu_wr_en, cpu_rd_en, tx_rst_ack, rx_rst_ack} = 5'h10;
    {jb_underrun, net_no_data, net_fill_allowed} = 3'h0;
    {cpu_addr, cpu_wdata, tdm_fill_index, net_fill_select} = 44'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_port();
    t_reset_req();
    t_fill();
    t_addr();
    finish_test();
  end
endmodule : tdm_port_reset_cond_regs_bench

//--- dv/tpcr_regs_sva.sv
// assertions on the ports of the register bank
`timescale 1ns/1ps
`include "tpcr_map.svh"

module tpcr_regs_sva
(
  input wire logic        clk,              // clock
  input wire logic        srst,             // sync reset
  input wire logic [7:0]  cpu_addr,         // byte address
  input wire logic        cpu_wr_en,        // write strobe
  input wire logic        cpu_rd_en,        // read strobe
  input wire logic [31:0] cpu_wdata,        // write data
  input wire logic        cpu_rvalid,       // read answer
  input wire logic        tx_rst_req,       // tx reset pending
  input wire logic        tx_rst_ack,       // tx reset ack
  input wire logic        rx_rst_req,       // rx reset pending
  input wire logic        rx_rst_ack,       // rx reset ack
  input wire logic        jb_underrun,      // buffer underrun
  input wire logic        tdm_fill_valid,   // tdm fill in use
  input wire logic        net_no_data,      // port has no data
  input wire logic        net_fill_allowed, // bundle type ok
  input wire logic        net_fill_valid    // net fill in use
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // write strobe aimed at the reset request register
  logic rst_wr;
  assign rst_wr = cpu_wr_en && (cpu_addr == `TPCR_OFF_RESET);

  chk_read_answer: assert property (cpu_rd_en |=> cpu_rvalid)
    else $error("read answer missing");
  chk_read_pulse: assert property (!cpu_rd_en |=> !cpu_rvalid)
    else $error("read answer without read");
  chk_tx_set: assert property (rst_wr && cpu_wdata[16] |=> tx_rst_req)
    else $error("tx reset not set");
  chk_tx_ack_clear: assert property
    (tx_rst_req && tx_rst_ack && !rst_wr |=> !tx_rst_req)
    else $error("tx reset not cleared by ack");
  chk_tx_hold: assert property
    (!tx_rst_ack && !rst_wr |=> $stable(tx_rst_req))
    else $error("tx reset changed alone");
  chk_rx_set: assert property (rst_wr && cpu_wdata[0] |=> rx_rst_req)
    else $error("rx reset not set");
  chk_rx_ack_clear: assert property
    (rx_rst_ack && !(rst_wr && cpu_wdata[0]) |=> !rx_rst_req)
    else $error("rx reset not cleared by ack");
  chk_rx_set_only: assert property
    (rx_rst_req && !rx_rst_ack |=> rx_rst_req)
    else $error("rx reset cleared without ack");
  chk_tdm_follow: assert property (jb_underrun |=> tdm_fill_valid)
    else $error("tdm fill not used in underrun");
  chk_tdm_idle: assert property (!jb_underrun |=> !tdm_fill_valid)
    else $error("tdm fill without underrun");
  chk_net_gate: assert property
    (net_no_data && net_fill_allowed |=> net_fill_valid)
    else $error("net fill missing");
  chk_net_block: assert property
    (!net_fill_allowed |=> !net_fill_valid)
    else $error("net fill on wrong bundle type");

  // main scenarios reached
  cov_tx_ack: cover property (tx_rst_req && tx_rst_ack);
  cov_rx_ack: cover property (rx_rst_req && rx_rst_ack);
  cov_net_fill: cover property (net_fill_valid);
endmodule : tpcr_regs_sva

bind tpcr_regs tpcr_regs_sva u_sva (.clk, .srst, .cpu_addr, .cpu_wr_en,
  .cpu_rd_en, .cpu_wdata, .cpu_rvalid, .tx_rst_req, .tx_rst_ack,
  .rx_rst_req, .rx_rst_ack, .jb_underrun, .tdm_fill_valid, .net_no_data,
  .net_fill_allowed, .net_fill_valid);

//--- hdl/tpcr_port_cfg.sv
// one port configuration word and its decoded edge controls
`timescale 1ns/1ps
`include "tpcr_map.svh"

module tpcr_port_cfg
  import tpcr_pkg::*;
(
  input  wire logic                    clk,          // system clock
  input  wire logic                    srst,         // sync reset
  input  wire logic                    wr_sel,       // write to this port
  input  wire logic [`TPCR_PCFG_W-1:0] wr_data,      // low write bits
  output logic      [`TPCR_PCFG_W-1:0] cfg,          // stored word
  output logic                         two_clock,    // rx on receive clk
  output logic                         tx_in_rise,   // tx inputs rising
  output logic                         tx_out_fall,  // tx outputs falling
  output logic                         rx_in_rise,   // rx inputs rising
  output tpcr_framing_t                framing,      // framing type
  output tpcr_line_t                   line_type     // interface type
);

  // reset word as a named constant, since a literal takes no bit select
  localparam logic [`TPCR_PCFG_W-1:0] cfg_rst_word = `TPCR_PCFG_RST;

  logic [`TPCR_PCFG_W-1:0] next_cfg;  // word after this cycle's write

  // write merge; the unused line code is refused so the field
  // never holds a value the interface logic cannot handle
  always_comb
  begin
    next_cfg = cfg;
    if (wr_sel)
    begin
      next_cfg = wr_data;
      if (wr_data[`TPCR_PCFG_TYPE_HI:`TPCR_PCFG_TYPE_LO] ==
          `TPCR_TYPE_UNUSED)
      begin
        // keep previous line type
        next_cfg[`TPCR_PCFG_TYPE_HI:`TPCR_PCFG_TYPE_LO] =
          cfg[`TPCR_PCFG_TYPE_HI:`TPCR_PCFG_TYPE_LO];
      end
    end
  end

  // stored word
  always_ff @(posedge clk)
  begin
    if (srst)
      cfg <= `TPCR_PCFG_RST;
    else
      cfg <= next_cfg;
  end

  // decoded controls, registered from the next word so they track cfg
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      two_clock   <= cfg_rst_word[`TPCR_PCFG_TWO_CLK];
      tx_in_rise  <= cfg_rst_word[`TPCR_PCFG_TX_EDGE];
      tx_out_fall <= cfg_rst_word[`TPCR_PCFG_TX_EDGE];
      rx_in_rise  <= cfg_rst_word[`TPCR_PCFG_RX_EDGE];
      framing     <= TPCR_FRM_UNFRAMED;
      line_type   <= TPCR_LINE_E1;
    end
    else
    begin
      // clock mode: one selects receive clock for rx side
      two_clock   <= next_cfg[`TPCR_PCFG_TWO_CLK];
      // zero: sample falling, update rising; one reverses both
      tx_in_rise  <= next_cfg[`TPCR_PCFG_TX_EDGE];
      tx_out_fall <= next_cfg[`TPCR_PCFG_TX_EDGE];
      // rx edge field only counts in two-clock mode
      if (next_cfg[`TPCR_PCFG_TWO_CLK])
        rx_in_rise <= next_cfg[`TPCR_PCFG_RX_EDGE];
      else
        rx_in_rise <= next_cfg[`TPCR_PCFG_TX_EDGE];
      framing   <= tpcr_framing_t'(
        next_cfg[`TPCR_PCFG_FRM_HI:`TPCR_PCFG_FRM_LO]);
      line_type <= tpcr_line_t'(
        next_cfg[`TPCR_PCFG_TYPE_HI:`TPCR_PCFG_TYPE_LO]);
    end
  end

endmodule : tpcr_port_cfg

//--- hdl/tpcr_regs.sv
// port configuration, reset request and conditioning register bank
`timescale 1ns/1ps
`include "tpcr_map.svh"

module tpcr_regs
  import tpcr_pkg::*;
#(
  parameter int NUM_PORTS = 8                      // TDM ports
)
(
  input  wire logic                 clk,             // 40 MHz clock
  input  wire logic                 srst,            // sync reset
  // processor port
  input  wire logic [7:0]           cpu_addr,        // byte address
  input  wire logic                 cpu_wr_en,       // write strobe
  input  wire logic                 cpu_rd_en,       // read strobe
  input  wire logic [31:0]          cpu_wdata,       // write data
  output logic      [31:0]          cpu_rdata,       // read data
  output logic                      cpu_rvalid,      // read data valid
  // per-port controls
  output logic [NUM_PORTS-1:0]      port_two_clock,  // receive clk used
  output logic [NUM_PORTS-1:0]      port_tx_in_rise, // tx sample rising
  output logic [NUM_PORTS-1:0]      port_tx_out_fall,// tx update falling
  output logic [NUM_PORTS-1:0]      port_rx_in_rise, // rx sample rising
  output tpcr_framing_t             port_framing [NUM_PORTS], // framing
  output tpcr_line_t                port_line [NUM_PORTS],    // line type
  // transmit bundle reset
  output logic                      tx_rst_req,      // request pending
  output logic [3:0]                tx_rst_port,     // port selector
  output logic [5:0]                tx_rst_bundle,   // bundle number
  output logic                      tx_rst_open,     // one: opening
  input  wire logic                 tx_rst_ack,      // payload machine ack
  // receive bundle reset
  output logic                      rx_rst_req,      // request pending
  output logic [5:0]                rx_rst_bundle,   // bundle number
  input  wire logic                 rx_rst_ack,      // classifier ack
  // conditioning toward TDM
  input  wire logic                 jb_underrun,     // buffer underrun
  input  wire logic [1:0]           tdm_fill_index,  // 0 = octet A
  output logic [7:0]                tdm_fill_byte,   // fill octet
  output logic                      tdm_fill_valid,  // fill in use
  // conditioning toward network
  input  wire logic                 net_no_data,     // port has no data
  input  wire logic                 net_fill_allowed,// bundle type ok
  input  wire logic [1:0]           net_fill_select, // 0 = octet A
  output logic [7:0]                net_fill_byte,   // fill octet
  output logic                      net_fill_valid,  // fill in use
  // classifier addresses
  output logic [31:0]               local_ip_first,  // first IPv4
  output logic [31:0]               local_ip_second, // second IPv4
  output logic [47:0]               local_station_first // station addr
);

  logic [`TPCR_PCFG_W-1:0] port_cfg [NUM_PORTS]; // stored port words
  logic [31:0]             tdm_fill;             // four TDM octets
  logic [31:0]             net_fill;             // four network octets
  logic [31:0]             rd_value;             // read mux result
  logic                    wr_rst;               // reset reg write
  logic                    tx_set;               // new tx reset
  logic                    rx_set;               // new rx reset

  assign wr_rst = cpu_wr_en && (cpu_addr == `TPCR_OFF_RESET);
  assign tx_set = wr_rst && cpu_wdata[`TPCR_RST_TX];
  assign rx_set = wr_rst && cpu_wdata[`TPCR_RST_RX];

  // one configuration word per port
  for (genvar g = 0; g < NUM_PORTS; g++)
  begin : g_port
    tpcr_port_cfg u_cfg
    (
      .clk         (clk),
      .srst        (srst),
      .wr_sel      (cpu_wr_en && (cpu_addr == 8'(`TPCR_PORT_BASE +
                    g * `TPCR_PORT_STRIDE))),
      .wr_data     (cpu_wdata[`TPCR_PCFG_W-1:0]),
      .cfg         (port_cfg[g]),
      .two_clock   (port_two_clock[g]),
      .tx_in_rise  (port_tx_in_rise[g]),
      .tx_out_fall (port_tx_out_fall[g]),
      .rx_in_rise  (port_rx_in_rise[g]),
      .framing     (port_framing[g]),
      .line_type   (port_line[g])
    );
  end

  // transmit reset fields and receive bundle, reloaded by every write to the reset register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_rst_port   <= 4'h0;
      tx_rst_bundle <= 6'h00;
      tx_rst_open   <= 1'b0;
      rx_rst_bundle <= 6'h00;
    end
    else if (wr_rst)
    begin
      tx_rst_port   <= cpu_wdata[`TPCR_RST_PORT_HI:`TPCR_RST_PORT_LO];
      tx_rst_bundle <= cpu_wdata[`TPCR_RST_TXB_HI:`TPCR_RST_TXB_LO];
      tx_rst_open   <= cpu_wdata[`TPCR_RST_PHASE];
      rx_rst_bundle <= cpu_wdata[`TPCR_RST_RXB_HI:`TPCR_RST_RXB_LO];
    end
  end

  // transmit reset bit: a new set beats an acknowledge in the same
  // cycle, so a back-to-back request is never silently dropped
  always_ff @(posedge clk)
  begin
    if (srst)
      tx_rst_req <= 1'b0;
    else if (tx_set)
      tx_rst_req <= 1'b1;
    else if (tx_rst_ack || wr_rst)
      tx_rst_req <= 1'b0;
  end

  // receive reset bit is set-only: writing zero has no effect
  always_ff @(posedge clk)
  begin
    if (srst)
      rx_rst_req <= 1'b0;
    else if (rx_set)
      rx_rst_req <= 1'b1;
    else if (rx_rst_ack)
      rx_rst_req <= 1'b0;
  end

  // plain read-write words
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tdm_fill            <= `TPCR_WORD_RST;
      net_fill            <= `TPCR_WORD_RST;
      local_ip_first      <= `TPCR_WORD_RST;
      local_ip_second     <= `TPCR_WORD_RST;
      local_station_first <= {`TPCR_MAC_HIGH_W'(0), `TPCR_WORD_RST};
    end
    else if (cpu_wr_en)
    begin
      if (cpu_addr == `TPCR_OFF_TDM_FILL)
        tdm_fill <= cpu_wdata;
      else if (cpu_addr == `TPCR_OFF_NET_FILL)
        net_fill <= cpu_wdata;
      else if (cpu_addr == `TPCR_OFF_IP_FIRST)
        local_ip_first <= cpu_wdata;
      else if (cpu_addr == `TPCR_OFF_IP_SECOND)
        local_ip_second <= cpu_wdata;
      else if (cpu_addr == `TPCR_OFF_MAC_LOW)
        local_station_first[31:0] <= cpu_wdata;
      else if (cpu_addr == `TPCR_OFF_MAC_HIGH)
        local_station_first[47:32] <=
          cpu_wdata[`TPCR_MAC_HIGH_W-1:0];
    end
  end

  // TDM fill: octet A sits in the top byte, D in the bottom
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tdm_fill_byte  <= `TPCR_BYTE_RST;
      tdm_fill_valid <= 1'b0;
    end
    else
    begin
      tdm_fill_valid <= jb_underrun;
      case (tdm_fill_index)
        2'h0:    tdm_fill_byte <= tdm_fill[31:24];
        2'h1:    tdm_fill_byte <= tdm_fill[23:16];
        2'h2:    tdm_fill_byte <= tdm_fill[15:8];
        default: tdm_fill_byte <= tdm_fill[7:0];
      endcase
    end
  end

  // network fill: octet A in the bottom byte, D in the top; only
  // bundle types that allow it get a fill octet
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      net_fill_byte  <= `TPCR_BYTE_RST;
      net_fill_valid <= 1'b0;
    end
    else
    begin
      net_fill_valid <= net_no_data && net_fill_allowed;
      case (net_fill_select)
        2'h0:    net_fill_byte <= net_fill[7:0];
        2'h1:    net_fill_byte <= net_fill[15:8];
        2'h2:    net_fill_byte <= net_fill[23:16];
        default: net_fill_byte <= net_fill[31:24];
      endcase
    end
  end

  // read mux; reserved and unmapped bits read as zero
  always_comb
  begin
    rd_value = `TPCR_WORD_RST;
    if (cpu_addr == `TPCR_OFF_RESET)
    begin
      rd_value[`TPCR_RST_PORT_HI:`TPCR_RST_PORT_LO] = tx_rst_port;
      rd_value[`TPCR_RST_TXB_HI:`TPCR_RST_TXB_LO]   = tx_rst_bundle;
      rd_value[`TPCR_RST_PHASE]                     = tx_rst_open;
      rd_value[`TPCR_RST_TX]                        = tx_rst_req;
      rd_value[`TPCR_RST_RXB_HI:`TPCR_RST_RXB_LO]   = rx_rst_bundle;
      rd_value[`TPCR_RST_RX]                        = rx_rst_req;
    end
    else if (cpu_addr == `TPCR_OFF_TDM_FILL)
      rd_value = tdm_fill;
    else if (cpu_addr == `TPCR_OFF_NET_FILL)
      rd_value = net_fill;
    else if (cpu_addr == `TPCR_OFF_IP_FIRST)
      rd_value = local_ip_first;
    else if (cpu_addr == `TPCR_OFF_IP_SECOND)
      rd_value = local_ip_second;
    else if (cpu_addr == `TPCR_OFF_MAC_LOW)
      rd_value = local_station_first[31:0];
    else if (cpu_addr == `TPCR_OFF_MAC_HIGH)
      rd_value[`TPCR_MAC_HIGH_W-1:0] = local_station_first[47:32];
    else
    begin
      // port words; upper port bits live elsewhere and read zero
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        if (cpu_addr == 8'(`TPCR_PORT_BASE + i * `TPCR_PORT_STRIDE))
          rd_value[`TPCR_PCFG_W-1:0] = port_cfg[i];
      end
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cpu_rdata  <= `TPCR_WORD_RST;
      cpu_rvalid <= 1'b0;
    end
    else
    begin
      cpu_rvalid <= cpu_rd_en;
      if (cpu_rd_en)
        cpu_rdata <= rd_value;
    end
  end

endmodule : tpcr_regs

//--- pkg/tpcr_map.svh
// register offsets, field positions and reset values of the bank
`ifndef TPCR_MAP_SVH
`define TPCR_MAP_SVH

// byte offsets on the processor port
`define TPCR_PORT_BASE     8'h08
`define TPCR_PORT_STRIDE   8'h04
`define TPCR_OFF_RESET     8'h2C
`define TPCR_OFF_TDM_FILL  8'h30
`define TPCR_OFF_NET_FILL  8'h34
`define TPCR_OFF_IP_FIRST  8'h38
`define TPCR_OFF_IP_SECOND 8'h3C
`define TPCR_OFF_MAC_LOW   8'h40
`define TPCR_OFF_MAC_HIGH  8'h44

// port configuration low field
`define TPCR_PCFG_W        7
`define TPCR_PCFG_RST      7'h51
`define TPCR_PCFG_RX_EDGE  6
`define TPCR_PCFG_TX_EDGE  5
`define TPCR_PCFG_TWO_CLK  4
`define TPCR_PCFG_FRM_HI   3
`define TPCR_PCFG_FRM_LO   2
`define TPCR_PCFG_TYPE_HI  1
`define TPCR_PCFG_TYPE_LO  0
`define TPCR_TYPE_UNUSED   2'h3

// reset control register fields
`define TPCR_RST_PORT_HI   27
`define TPCR_RST_PORT_LO   24
`define TPCR_RST_TXB_HI    23
`define TPCR_RST_TXB_LO    18
`define TPCR_RST_PHASE     17
`define TPCR_RST_TX        16
`define TPCR_RST_RXB_HI    6
`define TPCR_RST_RXB_LO    1
`define TPCR_RST_RX        0

// station address high width and reset values
`define TPCR_MAC_HIGH_W    16
`define TPCR_WORD_RST      32'h0000_0000
`define TPCR_BYTE_RST      8'h00

`endif

//--- pkg/tpcr_pkg.sv
// types shared by the port and register bank modules
package tpcr_pkg;

  // framing of a port interface
  typedef enum logic [1:0]
  {
    TPCR_FRM_UNFRAMED  = 2'h0,
    TPCR_FRM_SYNC_ONLY = 2'h1,
    TPCR_FRM_MULTI     = 2'h2,
    TPCR_FRM_EXTENDED  = 2'h3
  } tpcr_framing_t;

  // line interface type
  typedef enum logic [1:0]
  {
    TPCR_LINE_SERIAL = 2'h0,
    TPCR_LINE_E1     = 2'h1,
    TPCR_LINE_T1     = 2'h2,
    TPCR_LINE_RSVD   = 2'h3
  } tpcr_line_t;

endpackage : tpcr_pkg
